// >>> urbm_receiver.sv
// Overview of operation
// - Flag parity mismatch of next buffered character
// - Parity flag follows buffer head until read
// - Disabling receiver aborts reception immediately
// - Disabled receiver releases the serial pin
// - Disabling receiver empties receive FIFO
// - Software flushes by reading until complete clears
// - Oversample sixteen times, eight in double speed
// - Realign bit timing on each start bit
// - Majority of three samples decides bit
// - Filter drops non-address frames
// - Filter leaves transmitter untouched
// - Frame type from stop or ninth bit
// - Type one is address, zero data
// - Master uses nine-bit frames, ninth marks address
// - Address frames buffered and flagged normally
// - Slave software toggles filter per address
// - Short frames need two stop bits
// - Sync polarity selects change and sample edges
// - Divisor twelve bits split high and low
// - Low divisor write reloads prescaler
// - Divisor change mid-frame unprotected
// - Divisor bits fifteen to twelve read zero
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
module urbm_receiver #(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial line
  urbm_link_if.rx          link,
  // Pin ownership
  output logic             rxPinOwned
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } urbm_rx_state_t;

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam logic [PTR_W:0] FIFO_FULL = (PTR_W + 1)'(FIFO_DEPTH);

  function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction

  urbm_rx_state_t                   state;
  logic                             ack;
  logic                             accept;
  logic [urbm_pkg::CTRL_W-2:0]      ctrl;
  logic [urbm_pkg::DIV_W-1:0]       divisor;
  logic [urbm_pkg::DIV_W-1:0]       presc;
  logic                             tick;
  logic                             prevSyncClk;
  logic [3:0]                       cnt;
  logic [3:0]                       bitIdx;
  logic [1:0]                       majShift;
  logic [8:0]                       rxShift;
  logic                             parityBit;
  logic [9:0]                       fifoMem [FIFO_DEPTH];
  logic [PTR_W-1:0]                 wrPtr;
  logic [PTR_W-1:0]                 rdPtr;
  logic [PTR_W:0]                   fillCount;
  logic [9:0]                       head;

  wire logic       rxd         = link.serialData;
  wire logic       rxEnable    = ctrl[urbm_pkg::CTRL_RX_EN];
  wire logic       mpFilter    = ctrl[urbm_pkg::CTRL_MP_FILTER];
  wire logic       doubleSpeed = ctrl[urbm_pkg::CTRL_DOUBLE_SPEED];
  wire logic       parityEn    = ctrl[urbm_pkg::CTRL_PARITY_EN];
  wire logic       parityOdd   = ctrl[urbm_pkg::CTRL_PARITY_ODD];
  wire logic       syncMode    = ctrl[urbm_pkg::CTRL_SYNC_MODE];
  wire logic       syncPol     = ctrl[urbm_pkg::CTRL_SYNC_POL];
  wire logic [3:0] dataBits    =
    urbm_pkg::frameDataBits(ctrl[urbm_pkg::CTRL_SIZE_LSB +: 3]);
  wire logic [3:0] lastIdx     = 4'(dataBits + {3'h0, parityEn} - 4'h1);

  // Avalon handshake: one wait state on every access
  assign waitrequest = (read | write) & ~(ack & ce);
  assign accept      = (read | write) & ack & ce;
  wire logic regWrite = accept & write;
  wire logic dataRead = accept & read & (address == urbm_pkg::REG_DATA);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= (read | write) & ~ack;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= urbm_pkg::CTRL_RESET[urbm_pkg::CTRL_W-2:0];
    end else if (ce && regWrite && address == urbm_pkg::REG_CTRL) begin
      ctrl <= writedata[urbm_pkg::CTRL_W-2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divisor <= urbm_pkg::DIV_RESET;
    end else if (ce && regWrite && address == urbm_pkg::REG_DIV_LOW) begin
      divisor[7:0] <= writedata[7:0];
    end else if (ce && regWrite && address == urbm_pkg::REG_DIV_HIGH) begin
      divisor[11:8] <= writedata[3:0];
    end
  end

  assign tick = (presc == '0);

  // immediate reload on low write; no guard on change
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      presc <= urbm_pkg::DIV_RESET;
    end else if (ce) begin
      if (regWrite && address == urbm_pkg::REG_DIV_LOW) begin
        presc <= {divisor[11:8], writedata[7:0]};
      end else if (tick) begin
        presc <= divisor;
      end else begin
        presc <= presc - 12'h001;
      end
    end
  end

  // sixteen or eight samples per bit
  wire logic [3:0] ovsLast     = doubleSpeed ? urbm_pkg::OVS_LAST_DOUBLE
                                             : urbm_pkg::OVS_LAST_NORMAL;
  wire logic [3:0] sampleFirst = doubleSpeed ? urbm_pkg::SAMPLE_FIRST_DOUBLE
                                             : urbm_pkg::SAMPLE_FIRST_NORMAL;
  wire logic [3:0] decideAt    = 4'(sampleFirst + 4'h2);
  wire logic       busy        = (state != ST_IDLE);
  wire logic       asyncStep   = ~syncMode & tick;

  // sample on falling edge for polarity 0, rising for 1
  wire logic syncEdge = syncMode & (prevSyncClk != link.syncClk) & (link.syncClk == syncPol);

  wire logic majority = (majShift[1] & majShift[0]) | (majShift[1] & rxd) | (majShift[0] & rxd);
  wire logic bitStrobe = syncMode ? (syncEdge & busy) : (asyncStep & busy & cnt == decideAt);
  wire logic bitValue  = syncMode ? rxd : majority;
  wire logic startSeen = rxEnable & ~busy & ~rxd & (syncMode ? syncEdge : asyncStep);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prevSyncClk <= 1'b0;
    end else if (ce) begin
      prevSyncClk <= link.syncClk;
    end
  end

  // bit counter restarts at the start edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 4'h0;
    end else if (ce) begin
      if (startSeen) begin
        cnt <= 4'h1;
      end else if (asyncStep && busy) begin
        cnt <= (cnt == ovsLast) ? 4'h0 : 4'(cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      majShift <= 2'h0;
    end else if (ce && asyncStep && busy && cnt >= sampleFirst && cnt < decideAt) begin
      majShift <= {majShift[0], rxd};
    end
  end

  // disable drops any frame in progress
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else if (ce) begin
      if (!rxEnable) begin
        state <= ST_IDLE;
      end else if (startSeen) begin
        state <= syncMode ? ST_DATA : ST_START;
      end else if (bitStrobe) begin
        unique case (state)
          ST_START: state <= bitValue ? ST_IDLE : ST_DATA;
          ST_DATA:  state <= (bitIdx == lastIdx) ? ST_STOP : ST_DATA;
          ST_STOP:  state <= ST_IDLE;
          ST_IDLE:  state <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bitIdx    <= 4'h0;
      rxShift   <= 9'h000;
      parityBit <= 1'b0;
    end else if (ce) begin
      if (startSeen) begin
        bitIdx  <= 4'h0;
        rxShift <= 9'h000;
      end else if (bitStrobe && state == ST_DATA) begin
        bitIdx <= 4'(bitIdx + 4'h1);
        if (bitIdx < dataBits) begin
          rxShift[bitIdx] <= bitValue;
        end else begin
          parityBit <= bitValue;
        end
      end
    end
  end

  // type from ninth bit or first stop; one means address
  wire logic frameType = (dataBits == urbm_pkg::DATA_BITS_MAX) ? rxShift[8] : bitValue;
  wire logic parityErr = parityEn & (urbm_pkg::parityOf(rxShift, dataBits, parityOdd) != parityBit);
  wire logic frameDone = bitStrobe & (state == ST_STOP) & rxEnable;
  // drop data frames under filter; address frames as normal
  wire logic push = frameDone & (~mpFilter | frameType) & (fillCount != FIFO_FULL);
  wire logic pop  = dataRead & (fillCount != '0);

  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      fifoMem[wrPtr] <= {parityErr, rxShift};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      fillCount <= '0;
    end else if (ce) begin
      if (!rxEnable) begin
        wrPtr     <= '0;
        rdPtr     <= '0;
        fillCount <= '0;
      end else begin
        if (push) begin
          wrPtr <= nextPtr(wrPtr);
        end
        if (pop) begin
          rdPtr <= nextPtr(rdPtr);
        end
        fillCount <= (PTR_W + 1)'(fillCount + {PTR_W'(0), push} - {PTR_W'(0), pop});
      end
    end
  end

  assign head = (fillCount != '0) ? fifoMem[rdPtr] : 10'h000;

  // upper divisor bits read as zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && !ack) begin
      unique case (address)
        urbm_pkg::REG_DATA:     readdata <= {23'h000000, head[8:0]};
        urbm_pkg::REG_CTRL:     readdata <= {22'h000000, ctrl};
        urbm_pkg::REG_DIV_LOW:  readdata <= {24'h000000, divisor[7:0]};
        urbm_pkg::REG_DIV_HIGH: readdata <= {28'h0000000, divisor[11:8]};
        urbm_pkg::REG_STATUS:   readdata <= {29'h00000000, head[8], head[9], fillCount != '0};
        default:                readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign rxPinOwned = rxEnable;

endmodule

// >>> urbm_pkg.sv
package urbm_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [4:0] REG_DATA     = 5'h00;
  localparam logic [4:0] REG_CTRL     = 5'h04;
  localparam logic [4:0] REG_DIV_LOW  = 5'h08;
  localparam logic [4:0] REG_DIV_HIGH = 5'h0c;
  localparam logic [4:0] REG_STATUS   = 5'h10;

  // Control register fields
  localparam int CTRL_W            = 11;
  localparam int CTRL_RX_EN        = 0;
  localparam int CTRL_MP_FILTER    = 1;
  localparam int CTRL_DOUBLE_SPEED = 2;
  localparam int CTRL_PARITY_EN    = 3;
  localparam int CTRL_PARITY_ODD   = 4;
  localparam int CTRL_SIZE_LSB     = 5;
  localparam int CTRL_SYNC_MODE    = 8;
  localparam int CTRL_SYNC_POL     = 9;
  localparam int CTRL_STOP_TWO     = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  // Status register fields
  localparam int STAT_RX_COMPLETE = 0;
  localparam int STAT_PARITY_ERR  = 1;
  localparam int STAT_NINTH_BIT   = 2;
  localparam int STAT_TX_BUSY     = 0;

  // Baud divisor
  localparam int              DIV_W     = 12;
  localparam logic [DIV_W-1:0] DIV_RESET = 12'h000;

  // Oversampling: last count per bit, first majority sample, half bit
  localparam logic [3:0] OVS_LAST_NORMAL     = 4'hf;
  localparam logic [3:0] OVS_LAST_DOUBLE     = 4'h7;
  localparam logic [3:0] SAMPLE_FIRST_NORMAL = 4'h7;
  localparam logic [3:0] SAMPLE_FIRST_DOUBLE = 4'h3;
  localparam logic [3:0] HALF_NORMAL         = 4'h8;
  localparam logic [3:0] HALF_DOUBLE         = 4'h4;

  // Character size codes
  localparam logic [2:0] CHAR_SIZE_9BIT = 3'h7;
  localparam logic [3:0] DATA_BITS_MAX  = 4'h9;

  // Data bits per character; reserved codes fall back to eight
  function automatic logic [3:0] frameDataBits(input logic [2:0] size);
    logic [3:0] n;
    n = 4'h8;
    case (size)
      3'h0:           n = 4'h5;
      3'h1:           n = 4'h6;
      3'h2:           n = 4'h7;
      3'h3:           n = 4'h8;
      CHAR_SIZE_9BIT: n = DATA_BITS_MAX;
      default:        n = 4'h8;
    endcase
    return n;
  endfunction

  // Expected parity bit over the low nbits of data
  function automatic logic parityOf(input logic [8:0] data, input logic [3:0] nbits,
                                    input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) begin
        p = p ^ data[i];
      end
    end
    return p;
  endfunction

endpackage

// >>> urbm_link_if.sv
interface urbm_link_if;
  logic serialData;
  logic syncClk;
  modport rx (input serialData, input syncClk);
  modport tx (output serialData, output syncClk);
endinterface

// >>> urbm_transmitter.sv
module urbm_transmitter (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Serial line
  urbm_link_if.tx          link
);

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } urbm_tx_state_t;

  urbm_tx_state_t               state;
  logic                         ack;
  logic                         accept;
  logic [urbm_pkg::CTRL_W-1:0]  ctrl;
  logic [urbm_pkg::DIV_W-1:0]   divisor;
  logic [urbm_pkg::DIV_W-1:0]   presc;
  logic [3:0]                   cnt;
  logic [3:0]                   bitsLeft;
  logic [12:0]                  frame;
  logic                         serialOut;
  logic                         syncClkOut;

  wire logic       doubleSpeed = ctrl[urbm_pkg::CTRL_DOUBLE_SPEED];
  wire logic       parityEn    = ctrl[urbm_pkg::CTRL_PARITY_EN];
  wire logic       syncPol     = ctrl[urbm_pkg::CTRL_SYNC_POL];
  wire logic       syncMode    = ctrl[urbm_pkg::CTRL_SYNC_MODE];
  wire logic       stopTwo     = ctrl[urbm_pkg::CTRL_STOP_TWO];
  wire logic [3:0] dataBits    =
    urbm_pkg::frameDataBits(ctrl[urbm_pkg::CTRL_SIZE_LSB +: 3]);
  wire logic [3:0] ovsLast     = doubleSpeed ? urbm_pkg::OVS_LAST_DOUBLE
                                             : urbm_pkg::OVS_LAST_NORMAL;
  wire logic [3:0] half        = doubleSpeed ? urbm_pkg::HALF_DOUBLE
                                             : urbm_pkg::HALF_NORMAL;
  wire logic       tick        = (presc == '0);
  wire logic       bitEnd      = tick & (state == TX_SHIFT) & (cnt == ovsLast);

  // Start, data LSB first, optional parity, then idle-level stops
  function automatic logic [12:0] buildFrame(input logic [8:0] data, input logic [3:0] nb,
                                             input logic par, input logic odd);
    logic [12:0] f;
    f = 13'h1fff;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nb) begin
        f[i + 1] = data[i];
      end
    end
    if (par) begin
      f[nb + 4'h1] = urbm_pkg::parityOf(data, nb, odd);
    end
    return f;
  endfunction

  wire logic [12:0] builtFrame = buildFrame(writedata[8:0], dataBits, parityEn,
                                            ctrl[urbm_pkg::CTRL_PARITY_ODD]);

  assign waitrequest = (read | write) & ~(ack & ce);
  assign accept      = (read | write) & ack & ce;
  wire logic regWrite  = accept & write;
  // Writes while a frame is on the line are dropped; poll busy first
  wire logic loadFrame = regWrite & (address == urbm_pkg::REG_DATA) & (state == TX_IDLE);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
    end else if (ce) begin
      ack <= (read | write) & ~ack;
    end
  end

  // filter bit stored only, framing ignores it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= urbm_pkg::CTRL_RESET;
    end else if (ce && regWrite && address == urbm_pkg::REG_CTRL) begin
      ctrl <= writedata[urbm_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divisor <= urbm_pkg::DIV_RESET;
    end else if (ce && regWrite && address == urbm_pkg::REG_DIV_LOW) begin
      divisor[7:0] <= writedata[7:0];
    end else if (ce && regWrite && address == urbm_pkg::REG_DIV_HIGH) begin
      divisor[11:8] <= writedata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      presc <= urbm_pkg::DIV_RESET;
    end else if (ce) begin
      if (regWrite && address == urbm_pkg::REG_DIV_LOW) begin
        presc <= {divisor[11:8], writedata[7:0]};
      end else if (tick) begin
        presc <= divisor;
      end else begin
        presc <= presc - 12'h001;
      end
    end
  end

  // ninth data bit marks address frames
  // two stop bits when the first carries the type
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= TX_IDLE;
      cnt       <= 4'h0;
      bitsLeft  <= 4'h0;
      frame     <= 13'h1fff;
      serialOut <= 1'b1;
    end else if (ce) begin
      if (loadFrame) begin
        state     <= TX_SHIFT;
        cnt       <= 4'h0;
        frame     <= {1'b1, builtFrame[12:1]};
        serialOut <= 1'b0;
        bitsLeft  <= 4'(dataBits + {3'h0, parityEn} + {3'h0, stopTwo} + 4'h1);
      end else if (state == TX_SHIFT && tick) begin
        cnt <= (cnt == ovsLast) ? 4'h0 : 4'(cnt + 4'h1);
        if (bitEnd) begin
          if (bitsLeft == 4'h0) begin
            state     <= TX_IDLE;
            serialOut <= 1'b1;
          end else begin
            serialOut <= frame[0];
            frame     <= {1'b1, frame[12:1]};
            bitsLeft  <= 4'(bitsLeft - 4'h1);
          end
        end
      end
    end
  end

  // data changes as clock leaves idle level, sampled on return
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncClkOut <= 1'b0;
    end else if (ce) begin
      syncClkOut <= (state == TX_SHIFT && syncMode && cnt < half) ? ~syncPol : syncPol;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (ce && read && !ack) begin
      unique case (address)
        urbm_pkg::REG_CTRL:     readdata <= {21'h000000, ctrl};
        urbm_pkg::REG_DIV_LOW:  readdata <= {24'h000000, divisor[7:0]};
        urbm_pkg::REG_DIV_HIGH: readdata <= {28'h0000000, divisor[11:8]};
        urbm_pkg::REG_STATUS:   readdata <= {31'h00000000, state == TX_SHIFT};
        default:                readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign link.serialData = serialOut;
  assign link.syncClk    = syncClkOut;

endmodule

// >>> urbm_link_monitor.sv
module urbm_link_monitor (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        ce,
  // Receiver register bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Pin ownership
  input wire logic        rxPinOwned,
  // Serial line
  input wire logic        serialData,
  input wire logic        syncClk
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic acc;
  logic ctrlWr;
  assign acc    = (read | write) & !waitrequest;
  assign ctrlWr = acc & write & (address == urbm_pkg::REG_CTRL);

  a_wait_one_state: assert property ($rose(read || write) && ce |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after one wait state");
  a_wait_idle_low: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high without a request");
  a_owned_follows_enable: assert property (ctrlWr |=> rxPinOwned == $past(writedata[0]))
    else $error("pin ownership differs from receiver enable");
  a_owned_holds_still: assert property (!ctrlWr |=> $stable(rxPinOwned))
    else $error("pin ownership changed without a control write");
  a_div_upper_zero: assert property (acc && read && address == urbm_pkg::REG_DIV_HIGH
                                     |-> readdata[31:4] == 28'h0)
    else $error("reserved divisor bits not zero");
  a_disabled_empty: assert property (acc && read && address == urbm_pkg::REG_STATUS && !rxPinOwned
                                     |-> readdata[urbm_pkg::STAT_RX_COMPLETE] == 1'b0)
    else $error("disabled receiver reports buffered data");
  a_unmapped_zero: assert property (acc && read && address[4:2] > 3'h4 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_read_data_hold: assert property (!read |=> $stable(readdata))
    else $error("read data moved without a read");

  c_rx_complete: cover property (acc && read && address == urbm_pkg::REG_STATUS && readdata[0]);
  c_parity_flag: cover property (acc && read && address == urbm_pkg::REG_STATUS && readdata[1]);
  c_div_reload: cover property (acc && write && address == urbm_pkg::REG_DIV_LOW);
  c_start_bit: cover property ($fell(serialData));
  c_sync_edge: cover property ($changed(syncClk));
endmodule

// >>> usart_receiver_baud_multiproc_tb.sv
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end

module usart_receiver_baud_multiproc_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        rstn;
  logic        ce;
  logic [4:0]  addr [2];
  logic        rd   [2];
  logic        wt   [2];
  logic [31:0] wd   [2];
  logic [31:0] rdq  [2];
  logic        wreq [2];
  logic        rxPinOwned;
  logic [31:0] q;
  logic [31:0] r;
  logic [2:0]  sz;
  logic [2:0]  szTab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
  int          failures;
  int          tests_run;
  int          seed;

  urbm_link_if link ();

  urbm_receiver #(.FIFO_DEPTH(2)) i_urbm_receiver (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .address(addr[0]), .read(rd[0]),
    .write(wt[0]), .writedata(wd[0]), .readdata(rdq[0]), .waitrequest(wreq[0]),
    .link(link.rx), .rxPinOwned(rxPinOwned));

  urbm_transmitter i_urbm_transmitter (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .address(addr[1]), .read(rd[1]),
    .write(wt[1]), .writedata(wd[1]), .readdata(rdq[1]), .waitrequest(wreq[1]),
    .link(link.tx));

  urbm_link_monitor i_urbm_link_monitor (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .address(addr[0]), .read(rd[0]),
    .write(wt[0]), .writedata(wd[0]), .readdata(rdq[0]), .waitrequest(wreq[0]),
    .rxPinOwned(rxPinOwned), .serialData(link.serialData), .syncClk(link.syncClk));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Side 0 is the receiver, side 1 the transmitter
  task automatic bus(input int s, input logic [4:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    addr[s] <= a;
    rd[s]   <= !w;
    wt[s]   <= w;
    wd[s]   <= d;
    // Read before this edge's updates land, so it is what the slave sees
    do @(posedge ref_clk); while (wreq[s] !== 1'b0);
    q = rdq[s];
    rd[s] <= 1'b0;
    wt[s] <= 1'b0;
  endtask

  task automatic cfg(input logic [10:0] c, input logic [11:0] dv);
    for (int s = 0; s < 2; s++) begin
      bus(s, urbm_pkg::REG_DIV_HIGH, 1'b1, {28'h0, dv[11:8]});
      bus(s, urbm_pkg::REG_DIV_LOW, 1'b1, {24'h0, dv[7:0]});
      bus(s, urbm_pkg::REG_CTRL, 1'b1, {21'h0, c});
    end
  endtask

  task automatic send(input logic [8:0] v);
    bus(1, urbm_pkg::REG_DATA, 1'b1, {23'h0, v});
    do bus(1, urbm_pkg::REG_STATUS, 1'b0, 32'h0); while (q[urbm_pkg::STAT_TX_BUSY] === 1'b1);
  endtask

  task automatic rxRead(input logic [4:0] a);
    bus(0, a, 1'b0, 32'h0);
  endtask

  function automatic logic [8:0] mask(input logic [2:0] s);
    return (s == 3'h7) ? 9'h1ff : (s > 3'h3) ? 9'h0ff : 9'((1 << (5 + s)) - 1);
  endfunction

  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    seed = 32'he504;
    failures = 0;
    tests_run = 0;
    rstn = 1'b0;
    ce = 1'b1;
    addr = '{5'h0, 5'h0};
    rd = '{1'b0, 1'b0};
    wt = '{1'b0, 1'b0};
    wd = '{32'h0, 32'h0};
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rxRead(urbm_pkg::REG_DIV_LOW);
    `CHK("div low reset", 32'h0, q)
    bus(0, urbm_pkg::REG_DIV_HIGH, 1'b1, 32'h0f);
    rxRead(urbm_pkg::REG_DIV_HIGH);
    `CHK("div high", 32'hf, q)
    bus(0, 5'h18, 1'b1, 32'hffff);
    rxRead(5'h18);
    `CHK("unmapped", 32'h0, q)
    // Random framing, divisor, speed, parity and clock mode
    for (int i = 0; i < 16; i++) begin
      sz = szTab[i % 6];
      r = $random(seed);
      cfg({r[5], r[0] & r[1], r[0], sz, r[2], r[3], r[4], 1'b0, 1'b1}, {10'h0, r[7:6]});
      send(r[16:8]);
      rxRead(urbm_pkg::REG_STATUS);
      `CHK("rx complete", 2'b01, q[1:0])
      rxRead(urbm_pkg::REG_DATA);
      `CHK("rx data", r[16:8] & mask(sz), q[8:0] & mask(sz))
    end
    // Odd parity sent to an even checker, then a clean character
    cfg(11'h069, 12'h001);
    bus(1, urbm_pkg::REG_CTRL, 1'b1, 32'h079);
    send(9'h0a5);
    bus(1, urbm_pkg::REG_CTRL, 1'b1, 32'h069);
    send(9'h03c);
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("parity first", 2'b11, q[1:0])
    rxRead(urbm_pkg::REG_DATA);
    `CHK("data first", 8'ha5, q[7:0])
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("parity next", 2'b01, q[1:0])
    rxRead(urbm_pkg::REG_DATA);
    `CHK("data next", 8'h3c, q[7:0])
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("drained", 1'b0, q[0])
    // Nine-bit filter: data frame dropped, address frame kept
    cfg(11'h0e3, 12'h000);
    send(9'h055);
    send(9'h1a7);
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("addr status", 3'b101, q[2:0])
    rxRead(urbm_pkg::REG_DATA);
    `CHK("addr frame", 9'h1a7, q[8:0])
    bus(0, urbm_pkg::REG_CTRL, 1'b1, 32'h0e1);
    send(9'h055);
    rxRead(urbm_pkg::REG_DATA);
    `CHK("data frame", 9'h055, q[8:0])
    // Short frames carry the type in the first stop bit
    cfg(11'h463, 12'h002);
    send(9'h0c3);
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("stop type", 1'b1, q[0])
    rxRead(urbm_pkg::REG_DATA);
    `CHK("stop frame", 8'hc3, q[7:0])
    // Disable with one character buffered and one in flight
    cfg(11'h061, 12'h000);
    send(9'h011);
    bus(1, urbm_pkg::REG_DATA, 1'b1, 32'h022);
    bus(0, urbm_pkg::REG_CTRL, 1'b1, 32'h060);
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("flushed", 1'b0, q[0])
    `CHK("pin released", 1'b0, rxPinOwned)
    send(9'h033);
    bus(0, urbm_pkg::REG_CTRL, 1'b1, 32'h061);
    rxRead(urbm_pkg::REG_STATUS);
    `CHK("aborted", 1'b0, q[0])
    // Both ends frozen mid-frame; the frame must resume intact
    bus(1, urbm_pkg::REG_DATA, 1'b1, 32'h05a);
    ce <= 1'b0;
    repeat (200) @(posedge ref_clk);
    ce <= 1'b1;
    bus(1, urbm_pkg::REG_STATUS, 1'b0, 32'h0);
    `CHK("frozen busy", 1'b1, q[urbm_pkg::STAT_TX_BUSY])
    do bus(1, urbm_pkg::REG_STATUS, 1'b0, 32'h0); while (q[urbm_pkg::STAT_TX_BUSY] === 1'b1);
    rxRead(urbm_pkg::REG_DATA);
    `CHK("after freeze", 9'h05a, q[8:0])
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule
